//--- logic/rcr_pkg.sv
// Package for the receiver configuration register bank
// Functional notes
// - One channel enabled: choice bit picks AM/PM
// - Both enabled, manual: choice bit feeds framing
// - Demod bit: peak or mixer; fast rate forces mixer
// - Lowpass and zero fields drive filter stages
// - Defaults at reset and set-default command
// - No CRC after REQA, WUPA, anticollision
// - Low-power receive bit enables low-power receive
// - Split bit routes inputs one/two to AM/PM
// - LF input bit flags LF signal present
// - AGC enable gates AGC; mode picks window
// - AGC algorithm bit: preset or reset based
// - Squelch starts 18.88 us after Tx, stops at timer
// - Mixer clock: transmit output or internal; single forces internal
// - AM first gain: 0 full, 1-6 cut, 7 boost
// - PM first gain uses same encoding
// - Clip bit clips stage outputs to 0.6 V
// - Peer gain force sets -6 dB, widest window
package rcr_pkg;
    localparam logic [7:0] RCR_OFS_CHAN_FILT = 8'h0a;
    localparam logic [7:0] RCR_OFS_AGC_INPUT = 8'h0b;
    localparam logic [7:0] RCR_OFS_FIRST_GAIN = 8'h0c;
    localparam logic [7:0] RCR_RST_CHAN_FILT = 8'h00;
    localparam logic [7:0] RCR_RST_AGC_INPUT = 8'h1a;
    localparam logic [7:0] RCR_RST_FIRST_GAIN = 8'hd8;
    localparam int RCR_CLK_MHZ = 100;
    localparam int RCR_SQUELCH_DLY_NS = 18880;
    localparam int RCR_SQUELCH_DLY_CYC = (RCR_SQUELCH_DLY_NS * RCR_CLK_MHZ + 999) / 1000;
    localparam logic [11:0] RCR_SQUELCH_CNT = 12'(RCR_SQUELCH_DLY_CYC);

    typedef struct packed {
        logic       channel_choice;
        logic       am_demod_mixer;
        logic [2:0] lowpass_ctl;
        logic       zero_sel_a;
        logic       zero_sel_b;
        logic       zero_sel_c;
    } rcr_chan_filt_t;

    typedef struct packed {
        logic receive_low_power;
        logic low_freq_split;
        logic low_freq_input_on;
        logic agc_enable;
        logic agc_whole_period;
        logic agc_reset_alg;
        logic squelch_auto;
        logic phase_mixer_clock_src;
    } rcr_agc_input_t;

    typedef struct packed {
        logic [2:0] am_first_gain;
        logic [2:0] pm_first_gain;
        logic       clip_enable;
        logic       peer_gain_force;
    } rcr_first_gain_t;

    typedef enum logic [1:0] {
        RCR_BUS_IDLE = 2'b00,
        RCR_BUS_ACK  = 2'b01
    } rcr_bus_st_t;
endpackage : rcr_pkg

//--- logic/rcr_regs.sv
// Receiver configuration registers with Avalon-MM slave and derived controls
`timescale 1ns/1ps
module rcr_regs (
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic [1:0]       o_avs_response,
    input  wire logic        i_set_default,
    input  wire logic        i_am_rx_enable,
    input  wire logic        i_pm_rx_enable,
    input  wire logic        i_manual_chan,
    input  wire logic        i_very_high_bit_rate,
    input  wire logic        i_single_ended,
    input  wire logic        i_tx_reqa,
    input  wire logic        i_tx_wupa,
    input  wire logic        i_anticoll_on,
    input  wire logic        i_tx_end,
    input  wire logic        i_mask_timer_expired,
    input  wire logic        i_subcarrier_pulse,
    input  wire logic        i_rx_active,
    input  wire logic        i_rx_frame_end,
    output logic             o_am_channel_on,
    output logic             o_pm_channel_on,
    output logic             o_framing_from_pm,
    output logic             o_am_demod_mixer,
    output logic [2:0]       o_lowpass_ctl,
    output logic [2:0]       o_zero_sel,
    output logic             o_rx_no_crc,
    output logic             o_receive_low_power,
    output logic             o_am_from_input_one,
    output logic             o_pm_from_input_two,
    output logic             o_lf_present,
    output logic             o_agc_run,
    output logic             o_agc_reset_alg,
    output logic             o_squelch_on,
    output logic             o_mixer_clk_internal,
    output logic [2:0]       o_am_first_gain,
    output logic [2:0]       o_pm_first_gain,
    output logic             o_clip_enable,
    output logic             o_peer_gain_force
);
    rcr_pkg::rcr_chan_filt_t  chan_filt_r;
    rcr_pkg::rcr_agc_input_t  agc_input_r;
    rcr_pkg::rcr_first_gain_t first_gain_r;
    rcr_pkg::rcr_bus_st_t     bus_st_r;
    logic [11:0]              sq_cnt_r;
    logic                     sq_wait_r;
    logic [3:0]               agc_pulse_r;
    logic                     no_crc_r;
    logic                     hit_cf;
    logic                     hit_ai;
    logic                     hit_fg;
    logic                     take;
    logic                     wr_lo;

    always_comb
    begin
        hit_cf = (i_avs_address == rcr_pkg::RCR_OFS_CHAN_FILT);
        hit_ai = (i_avs_address == rcr_pkg::RCR_OFS_AGC_INPUT);
        hit_fg = (i_avs_address == rcr_pkg::RCR_OFS_FIRST_GAIN);
    end

    // One wait state per access; answer registered in the ack state
    assign take = (bus_st_r == rcr_pkg::RCR_BUS_ACK);
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~take;
    assign wr_lo = take & i_avs_write & i_avs_byteenable[0];

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            bus_st_r <= rcr_pkg::RCR_BUS_IDLE;
        else
        begin
            case (bus_st_r)
                rcr_pkg::RCR_BUS_IDLE:
                    if (i_avs_read | i_avs_write)
                        bus_st_r <= rcr_pkg::RCR_BUS_ACK;
                rcr_pkg::RCR_BUS_ACK:
                    bus_st_r <= rcr_pkg::RCR_BUS_IDLE;
                default:
                    bus_st_r <= rcr_pkg::RCR_BUS_IDLE;
            endcase
        end
    end

    // Read path has no side effect; data captured on entry, held through ack
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_avs_readdata <= 32'h0000_0000;
            o_avs_response <= 2'b00;
        end
        else if (!take)
        begin
            o_avs_readdata <= 32'h0000_0000;
            o_avs_response <= 2'b00;
            if (hit_cf)
                o_avs_readdata <= {24'h00_0000, chan_filt_r};
            else if (hit_ai)
                o_avs_readdata <= {24'h00_0000, agc_input_r};
            else if (hit_fg)
                o_avs_readdata <= {24'h00_0000, first_gain_r};
            else
                o_avs_response <= 2'b10;
        end
    end

    // Set-default overrides a same-cycle write
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            chan_filt_r <= rcr_pkg::RCR_RST_CHAN_FILT;
        else if (i_set_default)
            chan_filt_r <= rcr_pkg::RCR_RST_CHAN_FILT;
        else if (wr_lo && hit_cf)
            chan_filt_r <= i_avs_writedata[7:0];
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            agc_input_r <= rcr_pkg::RCR_RST_AGC_INPUT;
        else if (i_set_default)
            agc_input_r <= rcr_pkg::RCR_RST_AGC_INPUT;
        else if (wr_lo && hit_ai)
            agc_input_r <= i_avs_writedata[7:0];
    end

    // First-stage gain, clip and peer gain force
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            first_gain_r <= rcr_pkg::RCR_RST_FIRST_GAIN;
        else if (i_set_default)
            first_gain_r <= rcr_pkg::RCR_RST_FIRST_GAIN;
        else if (wr_lo && hit_fg)
            first_gain_r <= i_avs_writedata[7:0];
    end

    // Channel enables and framing source
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_am_channel_on   <= 1'b0;
            o_pm_channel_on   <= 1'b0;
            o_framing_from_pm <= 1'b0;
        end
        else if (i_am_rx_enable ^ i_pm_rx_enable)
        begin
            o_am_channel_on   <= ~chan_filt_r.channel_choice;
            o_pm_channel_on   <= chan_filt_r.channel_choice;
            o_framing_from_pm <= chan_filt_r.channel_choice;
        end
        else if (i_am_rx_enable && i_pm_rx_enable)
        begin
            o_am_channel_on <= 1'b1;
            o_pm_channel_on <= 1'b1;
            if (i_manual_chan)
                o_framing_from_pm <= chan_filt_r.channel_choice;
        end
        else
        begin
            o_am_channel_on <= 1'b0;
            o_pm_channel_on <= 1'b0;
        end
    end

    // Static analog controls registered to keep outputs glitch free
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_am_demod_mixer     <= 1'b0;
            o_lowpass_ctl        <= 3'h0;
            o_zero_sel           <= 3'h0;
            o_receive_low_power  <= 1'b0;
            o_am_from_input_one  <= 1'b0;
            o_pm_from_input_two  <= 1'b0;
            o_lf_present         <= 1'b0;
            o_agc_reset_alg      <= 1'b0;
            o_mixer_clk_internal <= 1'b0;
            o_am_first_gain      <= 3'h0;
            o_pm_first_gain      <= 3'h0;
            o_clip_enable        <= 1'b0;
            o_peer_gain_force    <= 1'b0;
        end
        else
        begin
            o_am_demod_mixer    <= chan_filt_r.am_demod_mixer | i_very_high_bit_rate;
            o_lowpass_ctl       <= chan_filt_r.lowpass_ctl;
            o_zero_sel          <= {chan_filt_r.zero_sel_a, chan_filt_r.zero_sel_b,
                                    chan_filt_r.zero_sel_c};
            o_receive_low_power <= agc_input_r.receive_low_power;
            o_am_from_input_one <= agc_input_r.low_freq_split;
            o_pm_from_input_two <= agc_input_r.low_freq_split;
            o_lf_present        <= agc_input_r.low_freq_input_on;
            o_agc_reset_alg     <= agc_input_r.agc_reset_alg;
            o_mixer_clk_internal <= agc_input_r.phase_mixer_clock_src
                                    | i_single_ended;
            o_am_first_gain     <= first_gain_r.am_first_gain;
            o_pm_first_gain     <= first_gain_r.pm_first_gain;
            o_clip_enable       <= first_gain_r.clip_enable;
            o_peer_gain_force   <= first_gain_r.peer_gain_force;
        end
    end

    // No-CRC receive held from REQA/WUPA until frame end
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            no_crc_r <= 1'b0;
        else if (i_tx_reqa || i_tx_wupa)
            no_crc_r <= 1'b1;
        else if (i_rx_frame_end)
            no_crc_r <= 1'b0;
    end
    assign o_rx_no_crc = no_crc_r | i_anticoll_on;

    // AGC window: first eight pulses unless whole-period mode
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            agc_pulse_r <= 4'h0;
        else if (!i_rx_active)
            agc_pulse_r <= 4'h0;
        else if (i_subcarrier_pulse && agc_pulse_r != 4'h8)
            agc_pulse_r <= agc_pulse_r + 4'h1;
    end
    assign o_agc_run = agc_input_r.agc_enable & i_rx_active
                       & (agc_input_r.agc_whole_period | (agc_pulse_r != 4'h8));

    // Squelch delay counter; timer expiry wins over a late start
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sq_cnt_r     <= 12'h000;
            sq_wait_r    <= 1'b0;
            o_squelch_on <= 1'b0;
        end
        else if (i_mask_timer_expired)
        begin
            sq_wait_r    <= 1'b0;
            o_squelch_on <= 1'b0;
        end
        else if (i_tx_end && agc_input_r.squelch_auto)
        begin
            sq_cnt_r  <= rcr_pkg::RCR_SQUELCH_CNT - 12'h001;
            sq_wait_r <= 1'b1;
        end
        else if (sq_wait_r)
        begin
            if (sq_cnt_r == 12'h000)
            begin
                sq_wait_r    <= 1'b0;
                o_squelch_on <= 1'b1;
            end
            else
                sq_cnt_r <= sq_cnt_r - 12'h001;
        end
    end

    a_demod_very_high_bit_rate: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_very_high_bit_rate |=> o_am_demod_mixer)
        else $error("fast rate did not force mixer");
    a_default_load: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_set_default |=> first_gain_r == rcr_pkg::RCR_RST_FIRST_GAIN)
        else $error("set default not loaded");
    a_single_chan: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_am_rx_enable ^ i_pm_rx_enable) |=>
        o_pm_channel_on == $past(chan_filt_r.channel_choice))
        else $error("single channel choice wrong");
    a_no_crc: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_tx_reqa && !i_rx_frame_end) |=> o_rx_no_crc)
        else $error("no crc not set after request");
    a_agc_gate: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !agc_input_r.agc_enable |-> !o_agc_run)
        else $error("agc ran while disabled");
    a_mix_single: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_single_ended |=> o_mixer_clk_internal)
        else $error("single ended not internal clock");
    sequence s_tx_done;
        i_tx_end && agc_input_r.squelch_auto && !i_mask_timer_expired;
    endsequence
    a_squelch_delay: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        s_tx_done ##1 (!i_mask_timer_expired && !i_tx_end)[*8] |-> !o_squelch_on
        || $past(o_squelch_on, 8))
        else $error("squelch started early");
    a_squelch_stop: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_mask_timer_expired |=> !o_squelch_on)
        else $error("squelch not stopped by timer");
    a_read_data: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_avs_read && hit_fg && !o_avs_waitrequest) |->
        o_avs_readdata == {24'h00_0000, $past(first_gain_r)})
        else $error("read data mismatch");
endmodule : rcr_regs

//--- testbench/tb.sv
// Self-checking bench for the receiver configuration register bank
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0, wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  be = 4'h0;
    logic        setd = 0, am_en = 0, pm_en = 0, man = 0, very_high_bit_rate = 0, se = 0;
    logic        reqa = 0, wupa = 0, acl = 0, txe = 0, mte = 0, scp = 0, rxa = 0, rfe = 0;
    logic [31:0] rdat;
    logic [1:0]  resp, rsx;
    logic        wreq, am_on, pm_on, fr_pm, mix, nocrc, lowp, in1, in2, lfp, agc, alg, sq;
    logic        mclk, clip, pgf;
    logic [2:0]  lpc, zs, amg, pmg;
    int          fails = 0, checks = 0, k;
    logic [31:0] seed = 32'h0000_003c, d, r;
    logic [7:0]  m [3];

    rcr_regs rcr_regs_inst (.i_core_clk(clk), .i_nrst(nrst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_avs_response(resp),
        .i_set_default(setd), .i_am_rx_enable(am_en), .i_pm_rx_enable(pm_en),
        .i_manual_chan(man), .i_very_high_bit_rate(very_high_bit_rate), .i_single_ended(se),
        .i_tx_reqa(reqa), .i_tx_wupa(wupa), .i_anticoll_on(acl), .i_tx_end(txe),
        .i_mask_timer_expired(mte), .i_subcarrier_pulse(scp), .i_rx_active(rxa),
        .i_rx_frame_end(rfe), .o_am_channel_on(am_on), .o_pm_channel_on(pm_on),
        .o_framing_from_pm(fr_pm), .o_am_demod_mixer(mix), .o_lowpass_ctl(lpc),
        .o_zero_sel(zs), .o_rx_no_crc(nocrc), .o_receive_low_power(lowp),
        .o_am_from_input_one(in1), .o_pm_from_input_two(in2), .o_lf_present(lfp),
        .o_agc_run(agc), .o_agc_reset_alg(alg), .o_squelch_on(sq),
        .o_mixer_clk_internal(mclk), .o_am_first_gain(amg), .o_pm_first_gain(pmg),
        .o_clip_enable(clip), .o_peer_gain_force(pgf));

    initial forever #5 clk = ~clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // Request held until the rising edge that samples waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v,
                       input logic [3:0] b, output logic [31:0] q, output logic [1:0] rs);
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wdat <= {xs() & 32'hffffff00} | 32'(v);
        be <= b;
        do
        begin
            @(posedge clk);
        end
        while (wreq !== 1'b0);
        q = rdat;
        rs = resp;
        rd <= 1'b0;
        wr <= 1'b0;
        if (w && b[0] && a >= 8'h0a && a <= 8'h0c)
            m[a - 8'h0a] = v;
    endtask : bus

    task automatic rd_chk(input logic [7:0] a);
        logic [31:0] q;
        logic [1:0] rs;
        bus(1'b0, a, 8'h00, 4'hf, q, rs);
        if (a >= 8'h0a && a <= 8'h0c)
        begin
            chk(q, 32'(m[a - 8'h0a]));
            chk(32'(rs), 32'h0);
        end
        else
        begin
            chk(q, 32'h0);
            chk(32'(rs), 32'h2);
        end
    endtask : rd_chk

    task automatic cfg_chk();
        repeat (2) @(negedge clk);
        chk(32'(mix), 32'(m[0][6] | very_high_bit_rate));
        chk(32'({lpc, zs}), 32'(m[0][5:0]));
        chk(32'(lowp), 32'(m[1][7]));
        chk(32'({in1, in2}), 32'({2{m[1][6]}}));
        chk(32'(lfp), 32'(m[1][5]));
        chk(32'(alg), 32'(m[1][2]));
        chk(32'(mclk), 32'(m[1][0] | se));
        chk(32'(amg), 32'(m[2][7:5]));
        chk(32'(pmg), 32'(m[2][4:2]));
        chk(32'(clip), 32'(m[2][1]));
        chk(32'(pgf), 32'(m[2][0]));
        if (am_en ^ pm_en)
            chk(32'({am_on, pm_on, fr_pm}), 32'({~m[0][7], m[0][7], m[0][7]}));
        if (am_en && pm_en && man)
            chk(32'(fr_pm), 32'(m[0][7]));
    endtask : cfg_chk

    task automatic stop_test();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    initial
    begin
        #200000;
        fails++;
        stop_test();
    end

    initial
    begin
        m[0] = 8'h00;
        m[1] = 8'h1a;
        m[2] = 8'hd8;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        for (k = 8'h0a; k <= 8'h0d; k++)
            rd_chk(8'(k));
        cfg_chk();
        $display("reset values done");
        for (k = 0; k < 40; k++)
        begin
            r = xs();
            @(posedge clk);
            {am_en, pm_en, man, very_high_bit_rate, se} <= r[4:0];
            bus(1'b1, 8'h0a + 8'(r[9:8]), r[23:16], {3'h0, r[12] | r[13]}, d, rsx);
            rd_chk(8'h0a + 8'(r[9:8]));
            cfg_chk();
        end
        $display("random access done");
        @(posedge clk);
        setd <= 1'b1;
        @(posedge clk);
        setd <= 1'b0;
        m[0] = 8'h00;
        m[1] = 8'h1a;
        m[2] = 8'hd8;
        for (k = 8'h0a; k <= 8'h0c; k++)
            rd_chk(8'(k));
        $display("set default done");
        for (k = 0; k < 2; k++)
        begin
            @(posedge clk);
            reqa <= (k == 0);
            wupa <= (k == 1);
            @(posedge clk);
            {reqa, wupa} <= 2'b00;
            @(negedge clk);
            chk(32'(nocrc), 32'h1);
            @(posedge clk);
            rfe <= 1'b1;
            @(posedge clk);
            rfe <= 1'b0;
            @(negedge clk);
            chk(32'(nocrc), 32'h0);
        end
        @(posedge clk);
        acl <= 1'b1;
        @(negedge clk);
        chk(32'(nocrc), 32'h1);
        @(posedge clk);
        acl <= 1'b0;
        $display("no crc done");
        @(posedge clk);
        txe <= 1'b1;
        @(posedge clk);
        txe <= 1'b0;
        // Delay of 18.88 us is 1888 cycles at 10 ns; look just before and at the rise
        repeat (1887) @(posedge clk);
        @(negedge clk);
        chk(32'(sq), 32'h0);
        @(posedge clk);
        @(negedge clk);
        chk(32'(sq), 32'h1);
        @(posedge clk);
        mte <= 1'b1;
        @(posedge clk);
        mte <= 1'b0;
        @(negedge clk);
        chk(32'(sq), 32'h0);
        $display("squelch done");
        @(posedge clk);
        rxa <= 1'b1;
        repeat (2) @(negedge clk);
        chk(32'(agc), 32'h1);
        bus(1'b1, 8'h0b, 8'h0a, 4'h1, d, rsx);
        @(negedge clk);
        chk(32'(agc), 32'h0);
        @(posedge clk);
        // Receiver stopped and restarted around the AGC mode change
        rxa <= 1'b0;
        // Preset-based algorithm for a short start of frame
        bus(1'b1, 8'h0b, 8'h12, 4'h1, d, rsx);
        @(posedge clk);
        rxa <= 1'b1;
        for (k = 0; k < 12; k++)
        begin
            @(posedge clk);
            scp <= 1'b1;
            @(posedge clk);
            scp <= 1'b0;
            @(negedge clk);
            if (k == 2 || k == 11)
                chk(32'(agc), 32'(k == 2));
        end
        $display("agc done");
        stop_test();
    end
endmodule : tb
